/* File: design/rtc_port_pkg.sv */
// shared constants and types for the two-wire slave port
package rtc_port_pkg;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int unsigned MCLK_PERIOD_NS              = 25;
  localparam int unsigned ACCESS_RECOVERY_INTERVAL_NS = 200000;
  localparam int unsigned ACCESS_RECOVERY_CYCLES      =
    (ACCESS_RECOVERY_INTERVAL_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned RECOVERY_CNT_W              = 16;

  // -------------------------------------------------------------------------
  // byte space and address
  // -------------------------------------------------------------------------
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned PTR_W       = 6;
  localparam int unsigned SPACE_BYTES = 64;
  localparam logic [7:0]  SLAVE_ADDR  = 8'hd0;
  localparam logic [5:0]  PTR_RESET   = 6'h00;
  localparam logic [5:0]  PTR_STEP    = 6'h01;
  localparam logic [7:0]  IDLE_BYTE   = 8'hff;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  TX_LAST_BIT   = 4'h7;

  // -------------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_LOAD_PTR = 2'h0,
    OP_WRITE    = 2'h1,
    OP_FETCH    = 2'h2,
    OP_ADVANCE  = 2'h3
  } cmd_op_type;

  typedef struct packed {
    cmd_op_type  op;
    logic [7:0]  data;
  } link_cmd_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_type;

  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_ADDR     = 8'h02,
    ST_ADDR_ACK = 8'h04,
    ST_RX       = 8'h08,
    ST_RX_ACK   = 8'h10,
    ST_TX       = 8'h20,
    ST_TX_ACK   = 8'h40,
    ST_IGNORE   = 8'h80
  } link_state_type;

endpackage

/* File: design/level_sync.sv */
// two-flop synchroniser for a group of levels
`timescale 1ns/100ps
module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  logic             clk,
  input  logic             resetn,
  input  logic             en,
  input  logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      q      <= '0;
    end else if (en) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

/* File: design/byte_space.sv */
// 64-byte store with registered read
`timescale 1ns/100ps
module byte_space (
  input  logic                             clk,
  input  logic                             resetn,
  input  logic                             en,
  input  logic                             wr_en,
  input  logic [rtc_port_pkg::PTR_W-1:0]  wr_addr,
  input  logic [rtc_port_pkg::BYTE_W-1:0] wr_data,
  input  logic [rtc_port_pkg::PTR_W-1:0]  rd_addr,
  output logic [rtc_port_pkg::BYTE_W-1:0] rd_data
);

  logic [rtc_port_pkg::BYTE_W-1:0] mem [rtc_port_pkg::SPACE_BYTES];

  always_ff @(posedge clk) begin
    if (en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else if (en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

/* File: design/rtc_two_wire_slave_port.sv */
// two-wire slave port: link engine on the sampling clock, byte space on mclk
`timescale 1ns/100ps

// Behaviour
// - bus idle only while both lines high
// - data falling with clock high is START
// - data rising with clock high is STOP
// - data stable during clock high, one bit
// - unlimited bytes between START and STOP
// - eight bits msb first, ninth is acknowledge
// - addressed receiver acknowledges every byte
// - acknowledge held low through clock high
// - on no-ack release data line, stop sending
// - first write byte loads word pointer
// - read address starts sending at pointer
// - read pointer advances only on acknowledge
// - keep sending consecutive bytes while acknowledged
// - direct read starts at last pointer
// - write data stored, pointer advances on ack
// - acknowledge address, word address, data bytes
// - power fail deselects, refuses reads, writes
// - on backup supply release all outputs
// - access stays inhibited for recovery interval
// - respond only to address d0h
// - 64 bytes reachable through one pointer
// - power fail aborts transfer, clears pointer
module rtc_two_wire_slave_port #(
  parameter int unsigned RECOVERY_CYCLES = rtc_port_pkg::ACCESS_RECOVERY_CYCLES
) (
  input  logic mclk,
  input  logic resetn,
  input  logic ce,
  input  logic sample_clk,
  input  logic scl_in,
  input  logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input  logic power_fail,
  input  logic on_backup,
  output logic access_inhibited
);

  localparam int unsigned CW = rtc_port_pkg::RECOVERY_CNT_W;
  localparam int unsigned PW = rtc_port_pkg::PTR_W;

  // -------------------------------------------------------------------------
  // link domain: synchronised inputs
  // -------------------------------------------------------------------------
  rtc_port_pkg::bus_lines_type  lines_s;
  rtc_port_pkg::bus_lines_type  lines_q;
  logic                         backup_l;
  logic                         inhibit_l;
  logic                         ack_tgl_s;
  logic                         ack_tgl_q;
  logic                         ce_l;
  logic                         inhibit_r;
  logic                         ack_tgl_r;
  logic [7:0]                   reply_r;

  level_sync #(
    .WIDTH (6)
  ) u_link_sync (
    .clk    (sample_clk),
    .resetn (resetn),
    .en     (1'b1),
    .d      ({scl_in, sda_in, on_backup, inhibit_r, ack_tgl_r, ce}),
    .q      ({lines_s.scl, lines_s.sda, backup_l, inhibit_l, ack_tgl_s, ce_l})
  );

  always_ff @(posedge sample_clk or negedge resetn) begin
    if (!resetn) begin
      lines_q   <= '{scl: 1'b1, sda: 1'b1};
      ack_tgl_q <= 1'b0;
    end else if (ce_l) begin
      lines_q   <= lines_s;
      ack_tgl_q <= ack_tgl_s;
    end
  end

  // -------------------------------------------------------------------------
  // link domain: bus conditions
  // -------------------------------------------------------------------------
  logic start_evt;
  logic stop_evt;
  logic scl_rise;
  logic scl_fall;
  logic abort;
  logic reply_evt;
  logic idle_r;

  always_comb begin
    start_evt = lines_s.scl & lines_q.scl & lines_q.sda & ~lines_s.sda;
    stop_evt  = lines_s.scl & lines_q.scl & ~lines_q.sda & lines_s.sda;
    scl_rise  = lines_s.scl & ~lines_q.scl;
    scl_fall  = ~lines_s.scl & lines_q.scl;
    abort     = inhibit_l | backup_l;
    reply_evt = ack_tgl_s ^ ack_tgl_q;
  end

  // free bus tracking
  always_ff @(posedge sample_clk or negedge resetn) begin
    if (!resetn) begin
      idle_r <= 1'b1;
    end else if (ce_l) begin
      if (start_evt) begin
        idle_r <= 1'b0;
      end else if (stop_evt) begin
        idle_r <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // link domain: protocol engine
  // -------------------------------------------------------------------------
  rtc_port_pkg::link_state_type state_r;
  logic [3:0]                   bit_cnt_r;
  logic [7:0]                   shift_r;
  logic [7:0]                   tx_shift_r;
  logic                         rw_r;
  logic                         first_r;
  logic                         got_ack_r;
  logic                         sda_oe_r;
  logic                         addr_hit;
  logic                         start_ok;

  always_comb begin
    addr_hit = (shift_r[7:1] == rtc_port_pkg::SLAVE_ADDR[7:1]) & ~abort;
    start_ok = start_evt & (idle_r | (state_r != rtc_port_pkg::ST_IDLE));
  end

  always_ff @(posedge sample_clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= rtc_port_pkg::ST_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      tx_shift_r <= rtc_port_pkg::IDLE_BYTE;
      rw_r       <= 1'b0;
      first_r    <= 1'b0;
      got_ack_r  <= 1'b0;
      sda_oe_r   <= 1'b0;
    end else if (ce_l) begin
      if (abort) begin
        state_r  <= rtc_port_pkg::ST_IDLE;
        sda_oe_r <= 1'b0;
      end else if (start_ok) begin
        state_r   <= rtc_port_pkg::ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r  <= 1'b0;
      end else if (stop_evt) begin
        state_r  <= rtc_port_pkg::ST_IDLE;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          rtc_port_pkg::ST_ADDR: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], lines_s.sda};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == rtc_port_pkg::BITS_PER_BYTE) begin
              if (addr_hit) begin
                rw_r     <= shift_r[0];
                sda_oe_r <= 1'b1;
                state_r  <= rtc_port_pkg::ST_ADDR_ACK;
              end else begin
                state_r  <= rtc_port_pkg::ST_IGNORE;
              end
            end
          end
          rtc_port_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (rw_r) begin
                sda_oe_r   <= ~tx_shift_r[7];
                tx_shift_r <= {tx_shift_r[6:0], 1'b1};
                state_r    <= rtc_port_pkg::ST_TX;
              end else begin
                sda_oe_r <= 1'b0;
                first_r  <= 1'b1;
                state_r  <= rtc_port_pkg::ST_RX;
              end
            end
          end
          rtc_port_pkg::ST_RX: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], lines_s.sda};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == rtc_port_pkg::BITS_PER_BYTE) begin
              sda_oe_r <= 1'b1;
              state_r  <= rtc_port_pkg::ST_RX_ACK;
            end
          end
          rtc_port_pkg::ST_RX_ACK: begin
            if (scl_fall) begin
              sda_oe_r  <= 1'b0;
              bit_cnt_r <= 4'h0;
              first_r   <= 1'b0;
              state_r   <= rtc_port_pkg::ST_RX;
            end
          end
          rtc_port_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_r == rtc_port_pkg::TX_LAST_BIT) begin
                sda_oe_r <= 1'b0;
                state_r  <= rtc_port_pkg::ST_TX_ACK;
              end else begin
                bit_cnt_r  <= bit_cnt_r + 4'h1;
                sda_oe_r   <= ~tx_shift_r[7];
                tx_shift_r <= {tx_shift_r[6:0], 1'b1};
              end
            end
          end
          rtc_port_pkg::ST_TX_ACK: begin
            if (scl_rise) begin
              got_ack_r <= ~lines_s.sda;
            end else if (scl_fall) begin
              if (got_ack_r) begin
                bit_cnt_r  <= 4'h0;
                sda_oe_r   <= ~tx_shift_r[7];
                tx_shift_r <= {tx_shift_r[6:0], 1'b1};
                state_r    <= rtc_port_pkg::ST_TX;
              end else begin
                sda_oe_r <= 1'b0;
                state_r  <= rtc_port_pkg::ST_IGNORE;
              end
            end
          end
          rtc_port_pkg::ST_IGNORE: begin
            sda_oe_r <= 1'b0;
          end
          rtc_port_pkg::ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          default: begin
            state_r  <= rtc_port_pkg::ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
      if (reply_evt) begin
        tx_shift_r <= reply_r;
      end
    end
  end

  // -------------------------------------------------------------------------
  // link domain: command issue to the byte space
  // -------------------------------------------------------------------------
  rtc_port_pkg::link_cmd_type cmd_r;
  logic                       req_tgl_r;
  logic                       issue;
  rtc_port_pkg::cmd_op_type   issue_op;

  always_comb begin
    issue    = 1'b0;
    issue_op = rtc_port_pkg::OP_FETCH;
    if (!abort && !start_evt && !stop_evt) begin
      if (state_r == rtc_port_pkg::ST_ADDR && scl_fall && addr_hit && shift_r[0] &&
          bit_cnt_r == rtc_port_pkg::BITS_PER_BYTE) begin
        issue    = 1'b1;
        issue_op = rtc_port_pkg::OP_FETCH;
      end else if (state_r == rtc_port_pkg::ST_RX_ACK && scl_rise) begin
        issue    = 1'b1;
        issue_op = first_r ? rtc_port_pkg::OP_LOAD_PTR : rtc_port_pkg::OP_WRITE;
      end else if (state_r == rtc_port_pkg::ST_TX_ACK && scl_rise && !lines_s.sda) begin
        issue    = 1'b1;
        issue_op = rtc_port_pkg::OP_ADVANCE;
      end
    end
  end

  always_ff @(posedge sample_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_r     <= '{op: rtc_port_pkg::OP_FETCH, data: 8'h00};
      req_tgl_r <= 1'b0;
    end else if (ce_l && issue) begin
      cmd_r.op   <= issue_op;
      cmd_r.data <= shift_r;
      req_tgl_r  <= ~req_tgl_r;
    end
  end

  // pin drive: data line only ever pulled low
  always_ff @(posedge sample_clk or negedge resetn) begin
    if (!resetn) begin
      sda_oe <= 1'b0;
    end else if (ce_l) begin
      sda_oe <= sda_oe_r & ~backup_l;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sda_out <= 1'b0;
    end else if (ce) begin
      sda_out <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // mclk domain: power fail and recovery
  // -------------------------------------------------------------------------
  logic          pf_s;
  logic          req_tgl_s;
  logic          req_tgl_q;
  logic [CW-1:0] rec_cnt_r;

  level_sync #(
    .WIDTH (2)
  ) u_main_sync (
    .clk    (mclk),
    .resetn (resetn),
    .en     (ce),
    .d      ({power_fail, req_tgl_r}),
    .q      ({pf_s, req_tgl_s})
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rec_cnt_r <= '0;
      inhibit_r <= 1'b1;
    end else if (ce) begin
      if (pf_s) begin
        rec_cnt_r <= CW'(RECOVERY_CYCLES);
      end else if (rec_cnt_r != '0) begin
        rec_cnt_r <= rec_cnt_r - CW'(1);
      end
      inhibit_r <= pf_s | (rec_cnt_r != '0);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      access_inhibited <= 1'b1;
    end else if (ce) begin
      access_inhibited <= inhibit_r;
    end
  end

  // -------------------------------------------------------------------------
  // mclk domain: pointer and command execution
  // -------------------------------------------------------------------------
  logic          req_evt;
  logic          exec;
  logic [PW-1:0] ptr_r;
  logic          pend1_r;
  logic          pend2_r;
  logic [7:0]    rd_data;

  always_comb begin
    req_evt = req_tgl_s ^ req_tgl_q;
    exec    = req_evt & ~inhibit_r;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      req_tgl_q <= 1'b0;
    end else if (ce) begin
      req_tgl_q <= req_tgl_s;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ptr_r <= rtc_port_pkg::PTR_RESET;
    end else if (ce) begin
      if (pf_s) begin
        ptr_r <= rtc_port_pkg::PTR_RESET;
      end else if (exec) begin
        case (cmd_r.op)
          rtc_port_pkg::OP_LOAD_PTR: ptr_r <= cmd_r.data[PW-1:0];
          rtc_port_pkg::OP_WRITE:    ptr_r <= ptr_r + rtc_port_pkg::PTR_STEP;
          rtc_port_pkg::OP_ADVANCE:  ptr_r <= ptr_r + rtc_port_pkg::PTR_STEP;
          rtc_port_pkg::OP_FETCH:    ptr_r <= ptr_r;
          default:                   ptr_r <= ptr_r;
        endcase
      end
    end
  end

  byte_space u_space (
    .clk     (mclk),
    .resetn  (resetn),
    .en      (ce),
    .wr_en   (exec && cmd_r.op == rtc_port_pkg::OP_WRITE),
    .wr_addr (ptr_r),
    .wr_data (cmd_r.data),
    .rd_addr (ptr_r),
    .rd_data (rd_data)
  );

  // reply once the read port shows the updated pointer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend1_r   <= 1'b0;
      pend2_r   <= 1'b0;
      reply_r   <= rtc_port_pkg::IDLE_BYTE;
      ack_tgl_r <= 1'b0;
    end else if (ce) begin
      pend1_r <= req_evt;
      pend2_r <= pend1_r;
      if (pend2_r) begin
        reply_r   <= inhibit_r ? rtc_port_pkg::IDLE_BYTE : rd_data;
        ack_tgl_r <= ~ack_tgl_r;
      end
    end
  end

endmodule

/* File: sim/rtc_port_props.sv */
// assertions on the two-wire slave port pins
`timescale 1ns/100ps
module rtc_port_props #(
  parameter int unsigned RECOVERY_CYCLES = 20
) (
  input logic mclk,
  input logic resetn,
  input logic sample_clk,
  input logic scl_in,
  input logic sda_in,
  input logic sda_oe,
  input logic power_fail,
  input logic on_backup,
  input logic access_inhibited
);
  localparam logic [15:0] REC_LIM = 16'(RECOVERY_CYCLES);
  localparam logic [15:0] REC_TOP = REC_LIM + 16'h000d;
  logic [15:0] cnt_r;
  // cycles since power fail went away, saturating
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= REC_TOP;
    end else if (power_fail) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r < REC_TOP) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  sequence s_quiet;
    !sda_oe [*8];
  endsequence
  AST_START_LISTENS:
    assert property (@(posedge sample_clk) disable iff (!resetn) s_start |-> s_quiet)
    else $error("drive during address bits");
  AST_STOP_RELEASES:
    assert property (@(posedge sample_clk) disable iff (!resetn) s_stop |-> s_quiet)
    else $error("drive after stop");
  AST_EDGE_LOW_CLOCK:
    assert property (@(posedge sample_clk) disable iff (!resetn)
      $changed(sda_oe) && !on_backup |-> !scl_in) else $error("drive change with clock high");
  AST_ACK_HELD:
    assert property (@(posedge sample_clk) disable iff (!resetn) $rose(sda_oe) |-> sda_oe [*8])
    else $error("drive too short");
  AST_BACKUP_RELEASE:
    assert property (@(posedge sample_clk) disable iff (!resetn) on_backup [*5] |-> !sda_oe)
    else $error("drive on backup");
  AST_INHIBIT_QUIET:
    assert property (@(posedge sample_clk) disable iff (!resetn)
      access_inhibited [*8] |-> !sda_oe) else $error("drive while inhibited");
  AST_FAIL_INHIBITS:
    assert property (@(posedge mclk) disable iff (!resetn)
      $rose(power_fail) |-> ##[1:4] access_inhibited) else $error("no inhibit on fail");
  AST_RECOVERY_HOLD:
    assert property (@(posedge mclk) disable iff (!resetn)
      !power_fail && cnt_r < REC_LIM |-> access_inhibited) else $error("recovery cut short");
  AST_RECOVERY_END:
    assert property (@(posedge mclk) disable iff (!resetn)
      cnt_r == REC_LIM + 16'h000c |-> !access_inhibited) else $error("recovery too long");
endmodule
bind rtc_two_wire_slave_port rtc_port_props #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_props (
  .mclk(mclk), .resetn(resetn), .sample_clk(sample_clk), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe(sda_oe), .power_fail(power_fail), .on_backup(on_backup),
  .access_inhibited(access_inhibited));

/* File: sim/bus_master_model.sv */
// behavioural two-wire bus master, open drain
`timescale 1ns/100ps
module bus_master_model (
  input  logic mclk,
  input  logic sda_line,
  output logic scl_low,
  output logic sda_low
);
  localparam int QTR = 50;
  int extra;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    extra = 0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic start_cond();
    sda_low <= 1'b0;
    wt(3 * QTR);
    scl_low <= 1'b0;
    wt(4 * QTR);
    sda_low <= 1'b1;
    wt(4 * QTR);
    scl_low <= 1'b1;
    wt(QTR);
  endtask
  task automatic stop_cond();
    sda_low <= 1'b1;
    wt(3 * QTR);
    scl_low <= 1'b0;
    wt(4 * QTR);
    sda_low <= 1'b0;
    wt(4 * QTR);
  endtask
  task automatic bit_xfer(input logic val, output logic seen);
    sda_low <= ~val;
    wt(3 * QTR + extra);
    scl_low <= 1'b0;
    wt(2 * QTR);
    seen = sda_line;
    wt(2 * QTR);
    scl_low <= 1'b1;
    wt(QTR);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic give_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      b[i] = s;
    end
    bit_xfer(~give_ack, s);
  endtask
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the two-wire slave port
`timescale 1ns/100ps
module testbench;
  localparam int unsigned REC = 20;
  logic       mclk;
  logic       sample_clk;
  logic       resetn;
  logic       ce;
  logic       power_fail;
  logic       on_backup;
  logic       sda_out;
  logic       sda_oe;
  logic       access_inhibited;
  logic       scl_low;
  logic       sda_low;
  logic       scl_line;
  logic       sda_line;
  logic [7:0] exp_mem [64];
  logic [5:0] ptr;
  int         fails;
  int         samples_checked;
  assign scl_line = ~scl_low;
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
  always #12.5 mclk = ~mclk;
  always #40 sample_clk = ~sample_clk;
  rtc_two_wire_slave_port #(.RECOVERY_CYCLES(REC)) u_rtc_two_wire_slave_port (
    .mclk(mclk), .resetn(resetn), .ce(ce), .sample_clk(sample_clk), .scl_in(scl_line),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .power_fail(power_fail),
    .on_backup(on_backup), .access_inhibited(access_inhibited));
  bus_master_model u_bus_master_model (
    .mclk(mclk), .sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low));
  // ---------------------------------------------------------------
  // compare and bus helpers
  // ---------------------------------------------------------------
  task automatic check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [5:0] next_ptr(input logic [5:0] p);
    return p + 6'h01;
  endfunction
  task automatic addr_phase(input logic [7:0] a, input logic exp_ack);
    logic ack;
    u_bus_master_model.start_cond();
    u_bus_master_model.send_byte(a, ack);
    check_bit("address ack", exp_ack, ack);
  endtask
  task automatic ptr_load(input logic [7:0] w);
    logic ack;
    addr_phase(8'hd0, 1'b1);
    u_bus_master_model.send_byte(w, ack);
    check_bit("word ack", 1'b1, ack);
    ptr = w[5:0];
  endtask
  task automatic write_data(input int n);
    logic       ack;
    logic [7:0] d;
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      u_bus_master_model.send_byte(d, ack);
      check_bit("data ack", 1'b1, ack);
      exp_mem[ptr] = d;
      ptr = next_ptr(ptr);
    end
    u_bus_master_model.stop_cond();
  endtask
  task automatic read_data(input int n);
    logic [7:0] d;
    for (int k = 0; k < n; k++) begin
      u_bus_master_model.recv_byte(k < n - 1, d);
      check_byte("read byte", exp_mem[ptr], d);
      if (k < n - 1) begin
        ptr = next_ptr(ptr);
      end
    end
    check_bit("released", 1'b0, sda_oe);
    check_bit("drive level", 1'b0, sda_out);
    u_bus_master_model.stop_cond();
  endtask
  initial begin
    repeat (98000) @(posedge mclk);
    fails++;
    results();
  end
  initial begin
    logic [7:0] a;
    logic       ack;
    int         cnt;
    mclk = 1'b0;
    sample_clk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    power_fail = 1'b0;
    on_backup = 1'b0;
    fails = 0;
    samples_checked = 0;
    ptr = 6'h00;
    cnt = $urandom(32'h8a2805cb);
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (60) @(negedge mclk);
    check_bit("inhibit idle", 1'b0, access_inhibited);
    ptr_load(8'h3e);
    write_data(3);
    ptr_load(8'hfe);
    addr_phase(8'hd1, 1'b1);
    read_data(3);
    addr_phase(8'hd1, 1'b1);
    read_data(1);
    a = 8'($urandom);
    if (a[7:1] == 7'h68) begin
      a = 8'h90;
    end
    addr_phase(a, 1'b0);
    u_bus_master_model.send_byte(8'h00, ack);
    check_bit("ignored ack", 1'b0, ack);
    u_bus_master_model.stop_cond();
    u_bus_master_model.extra = 60;
    ptr_load({2'b00, 6'($urandom_range(60, 1))});
    write_data(1);
    u_bus_master_model.extra = 0;
    power_fail <= 1'b1;
    repeat (10) @(negedge mclk);
    check_bit("inhibit on fail", 1'b1, access_inhibited);
    addr_phase(8'hd0, 1'b0);
    u_bus_master_model.stop_cond();
    power_fail <= 1'b0;
    ptr = 6'h00;
    cnt = 0;
    while (access_inhibited !== 1'b0 && cnt < REC + 100) begin
      @(negedge mclk);
      cnt++;
    end
    check_bit("recovery span", 1'b1, cnt >= REC && cnt <= REC + 12);
    if (access_inhibited !== 1'b0) begin
      results();
    end
    addr_phase(8'hd1, 1'b1);
    read_data(1);
    on_backup <= 1'b1;
    addr_phase(8'hd0, 1'b0);
    u_bus_master_model.stop_cond();
    on_backup <= 1'b0;
    results();
  end
endmodule
